// ===== dsw_map.svh
// Constants for the drive state word block: bit positions, codes and widths
// Summary of operation
// - State flags sit at fixed word bit positions
// - Power applied bit always reads one
// - Emergency halt bit low during quick stop
// - Warning bit always reads zero
// - Host managed bit always reads one
// - Goal met set when set-point reached
// - Goal met set on operating mode change
// - New target write re-evaluates goal met
// - Goal met set when halted at standstill
// - Same target value leaves goal met alone
// - Limit hit bit set at current limit
// - Bit 10 meaning follows control halt bit
// - Off, inhibited and fault states coded fixed
// - Enabled path states coded with bit five
// - Position mode bit 12 is set-point acknowledge
// - Bit 13 reads zero in profile modes
// - Velocity mode bit 12 means speed zero
// - Host picks channel one..N, gets 16 bits
`ifndef DSW_MAP_SVH
`define DSW_MAP_SVH

`define DSW_NUM_CH        2
`define DSW_CH_W          8
`define DSW_WORD_W        16
`define DSW_TGT_W         32

`define DSW_BIT_ARMED     0
`define DSW_BIT_ON        1
`define DSW_BIT_OPEN      2
`define DSW_BIT_FAULT     3
`define DSW_BIT_POWER     4
`define DSW_BIT_EHALT     5
`define DSW_BIT_INHIB     6
`define DSW_BIT_WARN      7
`define DSW_BIT_HOST      9
`define DSW_BIT_GOAL      10
`define DSW_BIT_LIMIT     11
`define DSW_BIT_MODE12    12
`define DSW_BIT_MODE13    13

`define DSW_CW_HALT       8

`define DSW_MODE_PP       8'h01
`define DSW_MODE_PV       8'h03

`define DSW_WORD_RESET    16'h0000

`endif

// ===== dsw_pkg.sv
// Types shared by the drive state word block
package dsw_pkg;

  typedef enum logic [2:0]
  {
    DSW_NOT_READY   = 3'b000,
    DSW_INHIBITED   = 3'b001,
    DSW_ARMED       = 3'b010,
    DSW_ON          = 3'b011,
    DSW_OP_ENABLED  = 3'b100,
    DSW_QSTOP       = 3'b101,
    DSW_FAULT_REACT = 3'b110,
    DSW_FAULT       = 3'b111
  } dsw_state_e;

  // Live drive status of one channel, from the motion core
  typedef struct packed
  {
    dsw_state_e  state;
    logic [7:0]  mode;
    logic [15:0] control;
    logic        at_setpoint;
    logic        standstill;
    logic        current_limit;
    logic        setpoint_busy;
    logic        tgt_write;
    logic [31:0] tgt_value;
  } dsw_chan_s;

endpackage

// ===== dsw_chan.sv
// One channel: goal met tracking and status word assembly
`timescale 1ns/100ps
`default_nettype none
`include "dsw_map.svh"

module dsw_chan
  import dsw_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Channel status
  input  wire dsw_chan_s  chan,
  // Assembled word
  output logic [15:0]     word
);

  logic [7:0]  mode_reg;
  logic [31:0] tgt_reg;
  logic        goal_reg;
  logic        goal_next;
  logic        halt;
  logic        mode_chg;
  logic        new_tgt;
  logic        goal_eval;
  logic        pp_mode;
  logic        pv_mode;
  logic [3:0]  low_code;
  logic        inhib;
  logic        ehalt;

  ////////////////////////////////////////////////////////////////////////////
  assign halt      = chan.control[`DSW_CW_HALT];
  assign mode_chg  = (chan.mode != mode_reg);
  assign new_tgt   = chan.tgt_write && (chan.tgt_value != tgt_reg);
  // With halt set the bit tracks standstill, else the set-point
  assign goal_eval = halt ? chan.standstill : chan.at_setpoint;

  // Between target writes the flag follows the live condition, so a new
  // target naturally drops it until the axis gets there again
  assign goal_next = mode_chg       ? 1'b1 :
                     new_tgt        ? goal_eval :
                     chan.tgt_write ? goal_reg : goal_eval;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      mode_reg <= 8'h00;
      tgt_reg  <= 32'h0000_0000;
      goal_reg <= 1'b0;
    end
    else
    begin
      mode_reg <= chan.mode;
      if (chan.tgt_write)
        tgt_reg <= chan.tgt_value;
      goal_reg <= goal_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [3:0] state_low(input dsw_state_e s);
    case (s)
      DSW_ARMED:       state_low = 4'h1;
      DSW_ON:          state_low = 4'h3;
      DSW_OP_ENABLED:  state_low = 4'h7;
      DSW_QSTOP:       state_low = 4'h7;
      DSW_FAULT_REACT: state_low = 4'hf;
      DSW_FAULT:       state_low = 4'h8;
      default:         state_low = 4'h0;
    endcase
  endfunction

  assign low_code = state_low(chan.state);
  assign inhib    = (chan.state == DSW_INHIBITED);
  // Quick stop reaction clears bit 5; the enabled path sets it
  assign ehalt    = (chan.state == DSW_ARMED) || (chan.state == DSW_ON) ||
                    (chan.state == DSW_OP_ENABLED);
  assign pp_mode  = (chan.mode == `DSW_MODE_PP);
  assign pv_mode  = (chan.mode == `DSW_MODE_PV);

  always_comb
  begin
    word                      = `DSW_WORD_RESET;
    word[3:0]                 = low_code;
    word[`DSW_BIT_POWER]      = 1'b1;
    word[`DSW_BIT_EHALT]      = ehalt;
    word[`DSW_BIT_INHIB]      = inhib;
    word[`DSW_BIT_WARN]       = 1'b0;
    word[`DSW_BIT_HOST]       = 1'b1;
    word[`DSW_BIT_GOAL]       = goal_reg;
    word[`DSW_BIT_LIMIT]      = chan.current_limit;
    word[`DSW_BIT_MODE12]     = pp_mode ? chan.setpoint_busy :
                                pv_mode ? chan.standstill : 1'b0;
    word[`DSW_BIT_MODE13]     = 1'b0;
  end

endmodule
`default_nettype wire

// ===== dsw_top.sv
// Drive state word: per channel status words and channel query port
`timescale 1ns/100ps
`default_nettype none
`include "dsw_map.svh"

module dsw_top
  import dsw_pkg::*;
(
  // Clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   RESET,
  // Channel status from the motion core
  input  wire dsw_chan_s              CHAN_STATUS [`DSW_NUM_CH],
  // Query port
  input  wire logic                   QUERY_VALID,
  input  wire logic [`DSW_CH_W-1:0]   QUERY_CHANNEL,
  output logic                        REPLY_VALID,
  output logic                        REPLY_ERROR,
  output logic [`DSW_WORD_W-1:0]      DRIVE_STATE_WORD
);

  logic [15:0] words [`DSW_NUM_CH];
  logic        ch_ok;
  logic [7:0]  ch_idx;
  logic        valid_reg;
  logic        error_reg;
  logic [15:0] data_reg;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < `DSW_NUM_CH; g = g + 1)
    begin : g_ch
      dsw_chan u_chan
      (
        .clk  (CORE_CLK),
        .rst  (RESET),
        .chan (CHAN_STATUS[g]),
        .word (words[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Channels count from one; zero and above the motor count are refused
  assign ch_ok  = (QUERY_CHANNEL != 8'h00) &&
                  (QUERY_CHANNEL <= 8'(`DSW_NUM_CH));
  assign ch_idx = QUERY_CHANNEL - 8'h01;

  always_ff @(posedge CORE_CLK)
  begin
    if (RESET)
    begin
      valid_reg <= 1'b0;
      error_reg <= 1'b0;
      data_reg  <= `DSW_WORD_RESET;
    end
    else
    begin
      valid_reg <= QUERY_VALID;
      error_reg <= QUERY_VALID && !ch_ok;
      if (QUERY_VALID)
        data_reg <= ch_ok ? words[ch_idx[0:0]] : `DSW_WORD_RESET;
    end
  end

  assign REPLY_VALID      = valid_reg;
  assign REPLY_ERROR      = error_reg;
  assign DRIVE_STATE_WORD = data_reg;

endmodule
`default_nettype wire

// ===== dsw_asserts.sv
// Checker of the drive state word query port
`timescale 1ns/100ps
`default_nettype none
module dsw_asserts
  import dsw_pkg::*;
(
  // Clock, reset and watched ports
  input wire logic        CORE_CLK,
  input wire logic        RESET,
  input wire dsw_chan_s   CHAN_STATUS [2],
  input wire logic        QUERY_VALID,
  input wire logic [7:0]  QUERY_CHANNEL,
  input wire logic        REPLY_VALID,
  input wire logic        REPLY_ERROR,
  input wire logic [15:0] DRIVE_STATE_WORD
);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RESET);
  wire ok = REPLY_VALID && !REPLY_ERROR;
  wire [15:0] w = DRIVE_STATE_WORD;
  wire q1 = QUERY_VALID && QUERY_CHANNEL == 8'h01;
  wire bad = QUERY_CHANNEL == 8'h00 || QUERY_CHANNEL > 8'h02;
  property p_rv; QUERY_VALID |=> REPLY_VALID; endproperty
  a_rv: assert property (p_rv) else $error("no reply");
  property p_nr; !QUERY_VALID |=> !REPLY_VALID; endproperty
  a_nr: assert property (p_nr) else $error("stray reply");
  property p_er; QUERY_VALID && bad |=> REPLY_ERROR && w == 16'h0000; endproperty
  a_er: assert property (p_er) else $error("bad channel");
  property p_fx; ok |-> w[4] && w[9] && !w[7]; endproperty
  a_fx: assert property (p_fx) else $error("fixed bits");
  property p_hi; ok |-> w[15:13] == 3'h0 && !w[8]; endproperty
  a_hi: assert property (p_hi) else $error("spare bits");
  property p_li; q1 |=> w[11] == $past(CHAN_STATUS[0].current_limit); endproperty
  a_li: assert property (p_li) else $error("limit bit");
  property p_pv; q1 && CHAN_STATUS[0].mode == 8'h03
    |=> w[12] == $past(CHAN_STATUS[0].standstill); endproperty
  a_pv: assert property (p_pv) else $error("speed bit");
  property p_ar; ok && w[3:0] == 4'h1 |-> w[6:5] == 2'b01; endproperty
  a_ar: assert property (p_ar) else $error("armed code");
endmodule
bind dsw_top dsw_asserts u_chk (.CORE_CLK, .RESET, .CHAN_STATUS, .QUERY_VALID,
  .QUERY_CHANNEL, .REPLY_VALID, .REPLY_ERROR, .DRIVE_STATE_WORD);
`default_nettype wire

// ===== dsw_host.sv
// Host model: issues status queries and takes the replies
`timescale 1ns/100ps
`default_nettype none
module dsw_host
(
  // Query out, reply in
  input  wire logic        clk,
  output var  logic        qv,
  output var  logic [7:0]  qch,
  input  wire logic [17:0] rep
);
  initial
  begin
    qv = 1'b0;
    qch = 8'h00;
  end
  task automatic ask(input logic [7:0] c, output logic [17:0] r);
    @(negedge clk);
    qv = 1'b1;
    qch = c;
    @(negedge clk);
    r = rep;
    qv = 1'b0;
    // Idle channel lines carry junk so a stale value cannot pass
    qch = ~c;
  endtask
endmodule
`default_nettype wire

// ===== tb.sv
// Testbench for the drive state word block
`timescale 1ns/100ps
`default_nettype none
module tb import dsw_pkg::*;;
  logic clk = 1'b0;
  logic rst, qv, rv, re;
  logic [7:0] qch;
  logic [15:0] rw;
  logic [17:0] r;
  dsw_chan_s cs [2];
  int n_mismatch = 0;
  int checks = 0;
  localparam logic [15:0] E [8] = '{16'h0210, 16'h0250, 16'h0231, 16'h0233,
    16'h0237, 16'h0217, 16'h021f, 16'h0218};
  dsw_top dut (.CORE_CLK(clk), .RESET(rst), .CHAN_STATUS(cs), .QUERY_VALID(qv),
    .QUERY_CHANNEL(qch), .REPLY_VALID(rv), .REPLY_ERROR(re), .DRIVE_STATE_WORD(rw));
  dsw_host host (.clk(clk), .qv(qv), .qch(qch), .rep({rv, re, rw}));
  task automatic chk(input string n, input logic [17:0] s, e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic q(input logic [7:0] c, input logic [17:0] e, input string n);
    host.ask(c, r);
    chk(n, r, e);
  endtask
  task automatic wrap_up;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial forever #5 clk = ~clk;
  initial
  begin
    #100000;
    n_mismatch++;
    wrap_up;
  end
  initial
  begin
    rst = 1'b1;
    cs = '{'0, '0};
    repeat (8) @(negedge clk);
    rst = 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      cs[0].state = dsw_state_e'(i);
      q(8'h01, {2'h2, E[i]}, "state");
    end
    cs[0].state = DSW_OP_ENABLED;
    cs[0].mode = 8'h03;
    cs[0].control = 16'h0100;
    cs[0].standstill = 1'b1;
    cs[0].current_limit = 1'b1;
    q(8'h01, 18'h21e37, "pv halt");
    cs[0].standstill = 1'b0;
    q(8'h01, 18'h20a37, "pv move");
    cs[1].state = DSW_OP_ENABLED;
    cs[1].mode = 8'h01;
    cs[1].at_setpoint = 1'b1;
    cs[1].setpoint_busy = 1'b1;
    q(8'h02, 18'h21637, "pp");
    cs[1].setpoint_busy = 1'b0;
    q(8'h02, 18'h20637, "pp idle");
    // Goal flag is one cycle late, so the mode change still shows
    cs[1].mode = 8'h06;
    cs[1].at_setpoint = 1'b0;
    q(8'h02, 18'h20637, "mode chg");
    q(8'h02, 18'h20237, "not met");
    // Write held high: the first edge takes the new target, later edges see it equal
    cs[1].tgt_value = 32'h0000_0005;
    cs[1].tgt_write = 1'b1;
    cs[1].at_setpoint = 1'b1;
    q(8'h02, 18'h20637, "new tgt");
    cs[1].at_setpoint = 1'b0;
    q(8'h02, 18'h20637, "same tgt");
    cs[1].tgt_write = 1'b0;
    q(8'h02, 18'h20237, "tgt done");
    q(8'h00, 18'h30000, "ch 0");
    q(8'h03, 18'h30000, "ch 3");
    wrap_up;
  end
endmodule
`default_nettype wire
